// File: dv/test_microcode_skip_and_entry_mapper.sv
// self-checking bench for the microsequencer
`timescale 1ns/1ps
module test_microcode_skip_and_entry_mapper;
   import mseq_pkg::*;
   localparam logic [4:0] df = 5'h05;  // flags a, b, carry_n, flag, overflow_n at rest
   logic        clk = 0, rst = 1, rd = 0, wr = 0, ssn = 0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [4:0]  f = df, cnt;
   logic [15:0] alu = 16'h0000, tb = 16'h0000, ir = 16'h0000;
   logic        wait_q, sub_q, rep_n, inv, ld;
   uaddr_t      uaddr, u, last = 9'h000;
   phase_t      phase;
   skip_code_t  code;
   int          errors = 0, n_checks = 0;
   logic [15:0] irs [13] = '{16'h4000, 16'h5000, 16'h6000, 16'h0000, 16'h0800, 16'h0500,
                             16'h0600, 16'h0700, 16'h0400, 16'h8500, 16'h8540, 16'h8080, 16'h8010};
   uaddr_t      ents [13] = '{ENTRY_ADD, ENTRY_CMP, ENTRY_LD, ENTRY_SRG_A, ENTRY_SRG_B,
                              ENTRY_ASG_CL, ENTRY_ASG_CM, ENTRY_ASG_CC, ENTRY_ASG_D, ENTRY_MI,
                              ENTRY_LI, ENTRY_MUL, ENTRY_ASHL};
   microcode_skip_and_entry_mapper DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(adr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF),
      .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_q), .I_SKIP_CODE(code),
      .I_INVERT_SKIP_SENSE(inv), .I_LOAD_REPEAT_COUNTER(ld), .I_A_ADDRESSED(f[4]),
      .I_B_ADDRESSED(f[3]), .I_CARRY_OUT_N(f[2]), .I_CPU_FLAG(f[1]), .I_OVERFLOW_N(f[0]),
      .I_SET_SUB_N(ssn), .I_ALU(alu), .I_TBUS(tb), .I_SBUS(ir), .I_IR(ir), .O_UADDR(uaddr),
      .O_PHASE(phase), .O_SUB_N(sub_q), .O_REPEAT_COUNT(cnt), .O_REPEAT_N(rep_n));
   ucode_rom_model rom_model (.i_uaddr(uaddr), .o_skip(code), .o_inv(inv), .o_load(ld));
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one avalon access; holds the request until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, exp);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wait_q !== 1'b0 && n < 50);
      check(n < 50, 1);
      if (!w) check(rdat, exp);
      rd <= 1'b0;
      wr <= 1'b0;
      #1;
   endtask
   // patch the word after the current one, run it, expect a step of 1 + d
   task automatic st(input skip_code_t c, input logic [1:0] il, input logic [4:0] fl,
                     input logic [15:0] a, t, i, input int d);
      u = uaddr;
      @(posedge clk);
      rom_model.rom[last] <= 6'h00;
      rom_model.rom[u + 1] <= {il, 4'(c)};
      last = u + 1;
      f <= fl;
      alu <= a;
      tb <= t;
      ir <= i;
      @(posedge clk);
      #1;
      if (d >= 0) check(uaddr, u + 2 + d);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // clock, watchdog and test sequence
   // ------------------------------------------------------------------
   initial begin
      forever #4 clk = ~clk;
   end
   // far longer than the few hundred cycles the tests need
   initial begin
      #100us;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(sub_q, 1);
      bus(0, REG_CTRL, 0, CTRL_RESET);
      bus(0, 4'h8, 0, 0);
      $display("bus test done");
      st(ab_register_addressed_skip, 0, 5'h15, 0, 0, 0, 1);
      st(ab_register_addressed_skip, 0, 5'h0D, 0, 0, 0, 1);
      st(ab_register_addressed_skip, 0, df, 0, 0, 0, 0);
      st(carry_out_skip, 0, 5'h01, 0, 0, 0, 1);
      st(carry_out_skip, 0, df, 0, 0, 0, 0);
      st(cpu_flag_skip, 0, 5'h07, 0, 0, 0, 1);
      st(cpu_flag_skip, 0, df, 0, 0, 0, 0);
      st(tbus_midbits_nonzero_skip, 0, df, 0, 16'h8001, 0, 0);
      st(tbus_midbits_nonzero_skip, 0, df, 0, 16'h4000, 0, 1);
      st(tbus_midbits_nonzero_skip, 0, df, 0, 16'h0002, 0, 1);
      st(sign_set_skip, 0, df, 16'h8000, 0, 0, 1);
      st(sign_set_skip, 0, df, 16'h7FFF, 0, 0, 0);
      st(parity_odd_skip, 0, df, 16'h0001, 0, 0, 1);
      st(parity_odd_skip, 0, df, 16'hFFFE, 0, 0, 0);
      st(overflow_clear_skip, 0, 5'h04, 0, 0, 0, 1);
      st(overflow_clear_skip, 0, df, 0, 0, 0, 0);
      st(tbus_zero_skip, 0, df, 0, 0, 0, 1);
      st(tbus_zero_skip, 0, df, 0, 16'h0001, 0, 0);
      st(tbus_zero_skip, 1, df, 0, 0, 0, 0);
      st(tbus_zero_skip, 1, df, 0, 16'h0001, 0, 1);
      st(always_skip, 0, df, 0, 0, 0, 1);
      st(always_skip, 1, df, 0, 0, 0, 0);
      st(protect_clear_skip, 0, df, 0, 0, 0, 1);
      st(protect_clear_skip, 0, 5'h15, 16'h8000, 0, 0, 0);
      bus(1, REG_CTRL, 32'h0000_0003, 0);
      bus(0, REG_CTRL, 0, 32'h0000_0003);
      st(protect_clear_skip, 0, df, 0, 0, 0, 0);
      st(protect_clear_skip, 0, df, 16'h8000, 0, 0, 1);
      $display("skip tests done");
      st(sk_none, 2, df, 0, 0, 16'h000F, 0);
      check(cnt, 5'h0F);
      st(counter_full_skip, 0, df, 0, 0, 0, 1);
      st(counter_full_skip_then_bump, 0, df, 0, 0, 0, 1);
      check(cnt, 5'h10);
      st(counter_full_skip, 0, df, 0, 0, 0, 0);
      repeat (15) st(bump_repeat_counter, 0, df, 0, 0, 0, 0);
      check(cnt, 5'h1F);
      st(counter_full_skip, 0, df, 0, 0, 0, 1);
      $display("counter tests done");
      st(repeat_next, 0, df, 0, 0, 0, 0);
      check(rep_n, 0);
      u = uaddr;
      @(posedge clk);
      rom_model.rom[last] <= 6'h00;
      rom_model.rom[u] <= {2'b00, 4'(tbus_zero_skip)};
      tb <= 16'h0001;
      repeat (3) @(posedge clk);
      #1;
      check(uaddr, u);
      @(posedge clk);
      tb <= 16'h0000;
      @(posedge clk);
      #1;
      check(uaddr, u + 1);
      check(rep_n, 1);
      last = u;
      $display("repeat test done");
      for (int k = 0; k < 13; k++) begin
         st(end_of_phase, 0, df, 0, 0, irs[k], -1);
         check(uaddr, ents[k]);
         check(phase, ph_execute);
         check(sub_q, 0);
         st(end_of_phase, 0, df, 0, 0, 0, -1);
         check(uaddr, ENTRY_FETCH);
      end
      $display("mapping tests done");
      wrap_up();
   end
endmodule // test_microcode_skip_and_entry_mapper

// File: dv/ucode_rom_model.sv
// microcode rom model that feeds the skip, invert and counter-load fields
`timescale 1ns/1ps
module ucode_rom_model (
   // address from the sequencer
   input  wire mseq_pkg::uaddr_t      i_uaddr,
   // microword fields back to the sequencer
   output mseq_pkg::skip_code_t       o_skip,
   output logic                       o_inv,
   output logic                       o_load
);
   import mseq_pkg::*;
   // ------------------------------------------------------------------
   // contents: {load, invert, skip code}
   // ------------------------------------------------------------------
   logic [5:0] rom [512];
   // blank words never skip, so an unpatched word just steps by one
   initial begin
      for (int i = 0; i < 512; i++) rom[i] = 6'h00;
   end
   // the rom answers within the cycle, like a plain asynchronous read
   assign o_skip = skip_code_t'(rom[i_uaddr][3:0]);
   assign o_inv  = rom[i_uaddr][4];
   assign o_load = rom[i_uaddr][5];
endmodule // ucode_rom_model

// File: hw/entry_mapper.sv
// maps a machine instruction to its microcode starting address
`timescale 1ns/1ps
module entry_mapper (
   // instruction in, entry out
   map_if.mapper m
);
   import mseq_pkg::*;

   logic [15:0] ir;
   assign ir = m.ir;

   // ------------------------------------------------------------------
   // decode, memory reference first, then register, i/o, extended
   // ------------------------------------------------------------------
   always_comb begin
      m.entry = ENTRY_FETCH;
      if (ir[IR_OPC_HI:IR_OPC_LO] != OPC_REG) begin
         case (ir[IR_OPC_HI:IR_OPC_LO])
            OPC_AJ:  m.entry = ir[IR_AB] ? ENTRY_SUBJ : ENTRY_AND;
            OPC_XJ:  m.entry = ir[IR_AB] ? ENTRY_JUMP : ENTRY_XOR;
            OPC_OI:  m.entry = ir[IR_AB] ? ENTRY_ISZ : ENTRY_IOR;
            OPC_ADD: m.entry = ENTRY_ADD;
            OPC_CMP: m.entry = ENTRY_CMP;
            OPC_LD:  m.entry = ENTRY_LD;
            default: m.entry = ENTRY_ST;
         endcase
      end else if (!ir[IR_IND] && !ir[IR_GRP]) begin
         m.entry = ir[IR_AB] ? ENTRY_SRG_B : ENTRY_SRG_A;
      end else if (!ir[IR_IND]) begin
         case (ir[IR_ASG_HI:IR_ASG_LO])
            ASG_CL:  m.entry = ENTRY_ASG_CL;
            ASG_CM:  m.entry = ENTRY_ASG_CM;
            ASG_CC:  m.entry = ENTRY_ASG_CC;
            default: m.entry = ENTRY_ASG_D;
         endcase
      end else if (ir[IR_GRP]) begin
         case (ir[IR_IOG_HI:IR_IOG_LO])
            IOG_MI:  m.entry = ENTRY_MI;
            IOG_LI:  m.entry = ENTRY_LI;
            IOG_OT:  m.entry = ENTRY_OT;
            IOG_CTL: m.entry = ir[IR_CLR] ? ENTRY_CLC : ENTRY_OT;
            default: m.entry = ENTRY_FLAG;
         endcase
      end else if (ir[IR_MUL]) begin
         m.entry = ir[IR_AB] ? ENTRY_DLOAD : ENTRY_MUL;
      end else if (ir[IR_DIV]) begin
         m.entry = ir[IR_AB] ? ENTRY_DSTORE : ENTRY_DIV;
      end else if (ir[IR_ARI]) begin
         m.entry = ir[IR_AB] ? ENTRY_ASHR : ENTRY_ASHL;
      end else if (ir[IR_LOG]) begin
         m.entry = ir[IR_AB] ? ENTRY_LSHR : ENTRY_LSHL;
      end else if (ir[IR_ROT]) begin
         m.entry = ENTRY_ROTL;
      end
   end
endmodule // entry_mapper

// File: hw/map_if.sv
// instruction-to-entry mapping carrier between sequencer and mapper
`timescale 1ns/1ps
interface map_if;
   logic [15:0]           ir;
   mseq_pkg::uaddr_t      entry;
   modport mapper (input ir, output entry);
   modport user   (output ir, input entry);
endinterface

// File: hw/microcode_skip_and_entry_mapper.sv
// microsequencer: skip evaluation, repeat, end of phase and entry mapping
//
// Notes on behaviour
// - addressed-register test skips if A or B addressed
// - carry-out test skips when carry occurred
// - counter-full skips on low four ones; variant bumps
// - end of phase jumps via mapper, clears subroutine
// - flag test skips when cpu flag set
// - bump code increments counter, never skips
// - middle-bits test skips if tbus 1..14 nonzero
// - sign test skips when alu bit 15 set
// - protect-clear skips if unaddressed and no violation
// - parity test skips when alu bit 0 set
// - overflow test skips when overflow ff cleared; the code skips when I_OVERFLOW_N is low
// - repeat code re-runs next word until skip
// - zero test skips when tbus all zero
// - always-skip code skips unless the invert bit is set
// - memory reference instructions map to fixed entries
// - shift group maps 100 for A, 104 B
// - alter group maps 25, 31, 35, else 21
// - flag and overflow ops 40, merge 60
// - load from io 64, output to io 70
// - multiply 210, divide 220, double load/store 310/320
// - double shifts map to 201, 202, 204, 241, 242
// - invert code reverses selected skip condition
// - counter loads from s-bus bits 0..3
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module microcode_skip_and_entry_mapper (
   // clock and reset
   input  wire logic                  I_SYS_CLK,
   input  wire logic                  I_RST,
   // avalon-mm register slave
   input  wire logic [3:0]            I_AVS_ADDRESS,
   input  wire logic                  I_AVS_READ,
   input  wire logic                  I_AVS_WRITE,
   input  wire logic [31:0]           I_AVS_WRITEDATA,
   input  wire logic [3:0]            I_AVS_BYTEENABLE,
   output logic [31:0]                O_AVS_READDATA,
   output logic                       O_AVS_WAITREQUEST,
   // microword fields from the rom
   input  wire mseq_pkg::skip_code_t  I_SKIP_CODE,
   input  wire logic                  I_INVERT_SKIP_SENSE,
   input  wire logic                  I_LOAD_REPEAT_COUNTER,
   // datapath state
   input  wire logic                  I_A_ADDRESSED,
   input  wire logic                  I_B_ADDRESSED,
   input  wire logic                  I_CARRY_OUT_N,
   input  wire logic                  I_CPU_FLAG,
   input  wire logic                  I_OVERFLOW_N,
   input  wire logic                  I_SET_SUB_N,
   input  wire logic [15:0]           I_ALU,
   input  wire logic [15:0]           I_TBUS,
   input  wire logic [15:0]           I_SBUS,
   input  wire logic [15:0]           I_IR,
   // sequencer state
   output mseq_pkg::uaddr_t           O_UADDR,
   output mseq_pkg::phase_t           O_PHASE,
   output logic                       O_SUB_N,
   output logic [4:0]                 O_REPEAT_COUNT,
   output logic                       O_REPEAT_N
);
   import mseq_pkg::*;

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   uaddr_t              uaddr;
   uaddr_t              next_uaddr;
   phase_t              phase;
   phase_t              next_phase;
   logic [CNT_W-1:0]    repeat_count;
   logic                repeat_n;
   logic                sub_n;
   logic [31:0]         ctrl;
   logic                ack;
   logic                cond;
   logic                is_test;
   logic                skip;
   logic                run;
   logic                protect_en;
   logic                ph_end;
   logic                bump;
   logic                mem_ref;
   map_if               map_bus ();

   // only the low four counter bits decide fullness
   function automatic logic count_full(input logic [CNT_W-1:0] c);
      return &c[CNT_LOAD_W-1:0];
   endfunction

   assign run        = ctrl[CTRL_RUN];
   assign protect_en = ctrl[CTRL_PROT];
   assign ph_end     = (I_SKIP_CODE == end_of_phase);
   assign bump       = (I_SKIP_CODE == bump_repeat_counter) ||
                       (I_SKIP_CODE == counter_full_skip_then_bump);
   assign mem_ref    = (I_IR[IR_OPC_HI:IR_OPC_LO] != OPC_REG);

   // ------------------------------------------------------------------
   // instruction mapper
   // ------------------------------------------------------------------
   assign map_bus.ir = I_IR;

   entry_mapper u_map (
      .m (map_bus.mapper)
   );

   // ------------------------------------------------------------------
   // skip condition select
   // ------------------------------------------------------------------
   // non-test codes never skip, even when inverted
   always_comb begin
      cond    = 1'b0;
      is_test = 1'b1;
      case (I_SKIP_CODE)
         ab_register_addressed_skip: begin
            cond = I_A_ADDRESSED | I_B_ADDRESSED;
         end
         carry_out_skip: begin
            cond = ~I_CARRY_OUT_N;
         end
         counter_full_skip, counter_full_skip_then_bump: begin
            cond = count_full(repeat_count);
         end
         cpu_flag_skip: begin
            cond = I_CPU_FLAG;
         end
         tbus_midbits_nonzero_skip: begin
            cond = |I_TBUS[MID_HI:MID_LO];
         end
         sign_set_skip: begin
            cond = I_ALU[SIGN_BIT];
         end
         protect_clear_skip: begin
            // bit 15 high here means no protect violation
            cond = ~(I_A_ADDRESSED | I_B_ADDRESSED) &
                   (~protect_en | I_ALU[SIGN_BIT]);
         end
         parity_odd_skip: begin
            cond = I_ALU[PARITY_BIT];
         end
         overflow_clear_skip: begin
            cond = ~I_OVERFLOW_N;
         end
         tbus_zero_skip: begin
            cond = ~|I_TBUS;
         end
         always_skip: begin
            cond = 1'b1;
         end
         default: begin
            is_test = 1'b0;
         end
      endcase
      skip = is_test & (cond ^ I_INVERT_SKIP_SENSE);
   end

   // ------------------------------------------------------------------
   // next microaddress and phase
   // ------------------------------------------------------------------
   // end of phase beats repeat and skip, so a phase never stalls
   always_comb begin
      next_uaddr = uaddr + UADDR_STEP;
      next_phase = phase;
      if (ph_end) begin
         case (phase)
            ph_fetch: begin
               if (mem_ref && I_IR[IR_IND]) begin
                  next_phase = ph_indirect;
                  next_uaddr = ENTRY_IND;
               end else begin
                  next_phase = ph_execute;
                  next_uaddr = map_bus.entry;
               end
            end
            ph_indirect: begin
               if (I_TBUS[IR_IND]) begin
                  next_uaddr = ENTRY_IND;
               end else begin
                  next_phase = ph_execute;
                  next_uaddr = map_bus.entry;
               end
            end
            default: begin
               next_phase = ph_fetch;
               next_uaddr = ENTRY_FETCH;
            end
         endcase
      end else if (!repeat_n) begin
         // held word runs again until its own test passes
         next_uaddr = skip ? uaddr + UADDR_STEP : uaddr;
      end else if (skip) begin
         next_uaddr = uaddr + UADDR_SKIP;
      end
   end

   // ------------------------------------------------------------------
   // sequencer state
   // ------------------------------------------------------------------
   // microaddress and phase advance only while running
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         uaddr <= ENTRY_FETCH;
         phase <= ph_fetch;
      end else if (run) begin
         uaddr <= next_uaddr;
         phase <= next_phase;
      end
   end

   // repeat counter: a load takes priority over a bump
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         repeat_count <= CNT_RESET;
      end else if (run && I_LOAD_REPEAT_COUNTER) begin
         repeat_count <= {1'b0, I_SBUS[CNT_LOAD_W-1:0]};
      end else if (run && bump) begin
         repeat_count <= repeat_count + CNT_STEP;
      end
   end

   // active-low repeat flip-flop
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         repeat_n <= 1'b1;
      end else if (run && repeat_n && I_SKIP_CODE == repeat_next) begin
         repeat_n <= 1'b0;
      end else if (run && !repeat_n && (skip || ph_end)) begin
         repeat_n <= 1'b1;
      end
   end

   // active-low subroutine flip-flop; the datapath set wins a tie
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         sub_n <= 1'b1;
      end else if (I_SET_SUB_N) begin
         sub_n <= 1'b1;
      end else if (run && ph_end) begin
         sub_n <= 1'b0;
      end
   end

   assign O_UADDR        = uaddr;
   assign O_PHASE        = phase;
   assign O_SUB_N        = sub_n;
   assign O_REPEAT_COUNT = repeat_count;
   assign O_REPEAT_N     = repeat_n;

   // ------------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------------
   // one wait state: ack rises the cycle after a request appears
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         ack <= 1'b0;
      end else begin
         ack <= (I_AVS_READ | I_AVS_WRITE) & ~ack;
      end
   end

   assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack;

   // control write lands on the edge where waitrequest is low
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         ctrl <= CTRL_RESET;
      end else if (I_AVS_WRITE && ack && I_AVS_ADDRESS == REG_CTRL &&
                   I_AVS_BYTEENABLE[0]) begin
         ctrl <= {30'h0000_0000, I_AVS_WRITEDATA[CTRL_PROT:CTRL_RUN]};
      end
   end

   // read data is captured a cycle early and holds through ack;
   // unmapped offsets read zero
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_AVS_READDATA <= 32'h0000_0000;
      end else if (I_AVS_READ && !ack) begin
         O_AVS_READDATA <= 32'h0000_0000;
         if (I_AVS_ADDRESS == REG_CTRL) begin
            O_AVS_READDATA <= ctrl;
         end else if (I_AVS_ADDRESS == REG_STATUS) begin
            O_AVS_READDATA[ST_UADDR_LO +: UADDR_W] <= uaddr;
            O_AVS_READDATA[ST_CNT_LO +: CNT_W]     <= repeat_count;
            O_AVS_READDATA[ST_PHASE_LO +: 2]       <= phase;
            O_AVS_READDATA[ST_SUB_N]               <= sub_n;
            O_AVS_READDATA[ST_REP_N]               <= repeat_n;
         end
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);

   chk_skip_by_two: assert property (
      run && repeat_n && skip && !ph_end |=> uaddr == $past(uaddr) + UADDR_SKIP)
      else $error("taken skip did not advance by two");

   chk_always_skip: assert property (
      I_SKIP_CODE == always_skip && !I_INVERT_SKIP_SENSE |-> skip)
      else $error("always-skip code did not skip");

   chk_bump_only: assert property (
      run && I_SKIP_CODE == bump_repeat_counter && !I_LOAD_REPEAT_COUNTER
      |-> !skip ##1 repeat_count == $past(repeat_count) + CNT_STEP)
      else $error("bump code skipped or missed the count");

   chk_end_sub_clear: assert property (
      run && ph_end && !I_SET_SUB_N |=> !sub_n)
      else $error("end of phase left subroutine ff set");

   chk_end_fetch: assert property (
      run && ph_end && phase == ph_execute
      |=> uaddr == ENTRY_FETCH && phase == ph_fetch)
      else $error("execute phase did not return to fetch");

   chk_end_mapped: assert property (
      run && ph_end && phase == ph_fetch && !mem_ref
      |=> phase == ph_execute && uaddr == $past(map_bus.entry))
      else $error("end of phase did not take mapped entry");

   chk_counter_load: assert property (
      run && I_LOAD_REPEAT_COUNTER
      |=> repeat_count == {1'b0, $past(I_SBUS[CNT_LOAD_W-1:0])})
      else $error("repeat counter load failed");

   chk_repeat_hold: assert property (
      run && !repeat_n && !skip && !ph_end |=> uaddr == $past(uaddr))
      else $error("repeated word was not held");

   chk_repeat_enter: assert property (
      run && repeat_n && I_SKIP_CODE == repeat_next
      |=> !repeat_n && uaddr == $past(uaddr) + UADDR_STEP)
      else $error("repeat code did not arm repeat");

   chk_counter_full: assert property (
      I_SKIP_CODE == counter_full_skip && !I_INVERT_SKIP_SENSE
      |-> skip == (&repeat_count[CNT_LOAD_W-1:0]))
      else $error("counter-full skip wrong");

   chk_protect_addr: assert property (
      I_SKIP_CODE == protect_clear_skip && !I_INVERT_SKIP_SENSE &&
      (I_A_ADDRESSED || I_B_ADDRESSED) |-> !skip)
      else $error("protect-clear skipped while a or b addressed");

   chk_invert_zero: assert property (
      I_SKIP_CODE == tbus_zero_skip |-> skip == ((I_TBUS == 16'h0000) ^
      I_INVERT_SKIP_SENSE))
      else $error("zero test or inversion wrong");
endmodule // microcode_skip_and_entry_mapper

// File: hw/mseq_pkg.sv
// constants and types shared by the microsequencer files
package mseq_pkg;
   // ------------------------------------------------------------------
   // microprogram address and microword codes
   // ------------------------------------------------------------------
   localparam int UADDR_W = 9;
   typedef logic [UADDR_W-1:0] uaddr_t;
   localparam uaddr_t UADDR_STEP = 9'h001;
   localparam uaddr_t UADDR_SKIP = 9'h002;
   typedef enum logic [3:0] {
      sk_none, ab_register_addressed_skip, carry_out_skip, counter_full_skip,
      counter_full_skip_then_bump, end_of_phase, cpu_flag_skip, bump_repeat_counter,
      tbus_midbits_nonzero_skip, sign_set_skip, protect_clear_skip, parity_odd_skip,
      overflow_clear_skip, repeat_next, tbus_zero_skip, always_skip
   } skip_code_t;
   typedef enum logic [1:0] {ph_fetch, ph_indirect, ph_execute} phase_t;
   // ------------------------------------------------------------------
   // datapath bit positions and repeat counter
   // ------------------------------------------------------------------
   localparam int SIGN_BIT   = 15;
   localparam int PARITY_BIT = 0;
   localparam int MID_HI     = 14;
   localparam int MID_LO     = 1;
   localparam int CNT_W      = 5;
   localparam int CNT_LOAD_W = 4;
   localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
   localparam logic [CNT_W-1:0] CNT_STEP  = 5'h01;
   // ------------------------------------------------------------------
   // instruction register fields
   // ------------------------------------------------------------------
   localparam int IR_IND    = 15;
   localparam int IR_OPC_HI = 14;
   localparam int IR_OPC_LO = 12;
   localparam int IR_AB     = 11;
   localparam int IR_GRP    = 10;
   localparam int IR_CLR    = 9;
   localparam int IR_ASG_HI = 9;
   localparam int IR_ASG_LO = 8;
   localparam int IR_IOG_HI = 8;
   localparam int IR_IOG_LO = 6;
   localparam int IR_DIV    = 8;
   localparam int IR_MUL    = 7;
   localparam int IR_ROT    = 6;
   localparam int IR_LOG    = 5;
   localparam int IR_ARI    = 4;
   localparam logic [2:0] OPC_REG  = 3'h0;
   localparam logic [2:0] OPC_AJ   = 3'h1;
   localparam logic [2:0] OPC_XJ   = 3'h2;
   localparam logic [2:0] OPC_OI   = 3'h3;
   localparam logic [2:0] OPC_ADD  = 3'h4;
   localparam logic [2:0] OPC_CMP  = 3'h5;
   localparam logic [2:0] OPC_LD   = 3'h6;
   localparam logic [1:0] ASG_CL   = 2'h1;
   localparam logic [1:0] ASG_CM   = 2'h2;
   localparam logic [1:0] ASG_CC   = 2'h3;
   localparam logic [2:0] IOG_MI   = 3'h4;
   localparam logic [2:0] IOG_LI   = 3'h5;
   localparam logic [2:0] IOG_OT   = 3'h6;
   localparam logic [2:0] IOG_CTL  = 3'h7;
   // ------------------------------------------------------------------
   // microcode entry points (octal value in the comment)
   // ------------------------------------------------------------------
   localparam uaddr_t ENTRY_FETCH  = 9'h000; // 000
   localparam uaddr_t ENTRY_IND    = 9'h00C; // 014
   localparam uaddr_t ENTRY_AND    = 9'h048; // 110
   localparam uaddr_t ENTRY_CMP    = 9'h04C; // 114
   localparam uaddr_t ENTRY_XOR    = 9'h050; // 120
   localparam uaddr_t ENTRY_JUMP   = 9'h054; // 124
   localparam uaddr_t ENTRY_IOR    = 9'h058; // 130
   localparam uaddr_t ENTRY_ST     = 9'h05C; // 134
   localparam uaddr_t ENTRY_ADD    = 9'h064; // 144
   localparam uaddr_t ENTRY_SUBJ   = 9'h068; // 150
   localparam uaddr_t ENTRY_LD     = 9'h074; // 164
   localparam uaddr_t ENTRY_ISZ    = 9'h078; // 170
   localparam uaddr_t ENTRY_SRG_A  = 9'h040; // 100
   localparam uaddr_t ENTRY_SRG_B  = 9'h044; // 104
   localparam uaddr_t ENTRY_ASG_D  = 9'h011; // 021
   localparam uaddr_t ENTRY_ASG_CL = 9'h015; // 025
   localparam uaddr_t ENTRY_ASG_CM = 9'h019; // 031
   localparam uaddr_t ENTRY_ASG_CC = 9'h01D; // 035
   localparam uaddr_t ENTRY_FLAG   = 9'h020; // 040
   localparam uaddr_t ENTRY_MI     = 9'h030; // 060
   localparam uaddr_t ENTRY_LI     = 9'h034; // 064
   localparam uaddr_t ENTRY_OT     = 9'h038; // 070
   localparam uaddr_t ENTRY_CLC    = 9'h03C; // 074
   localparam uaddr_t ENTRY_MUL    = 9'h088; // 210
   localparam uaddr_t ENTRY_DIV    = 9'h090; // 220
   localparam uaddr_t ENTRY_DLOAD  = 9'h0C8; // 310
   localparam uaddr_t ENTRY_DSTORE = 9'h0D0; // 320
   localparam uaddr_t ENTRY_ASHL   = 9'h081; // 201
   localparam uaddr_t ENTRY_LSHL   = 9'h082; // 202
   localparam uaddr_t ENTRY_ROTL   = 9'h084; // 204
   localparam uaddr_t ENTRY_ASHR   = 9'h0A1; // 241
   localparam uaddr_t ENTRY_LSHR   = 9'h0A2; // 242
   // ------------------------------------------------------------------
   // register bus map
   // ------------------------------------------------------------------
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h4;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
   localparam int CTRL_RUN    = 0;
   localparam int CTRL_PROT   = 1;
   localparam int ST_UADDR_LO = 0;
   localparam int ST_CNT_LO   = 16;
   localparam int ST_PHASE_LO = 24;
   localparam int ST_SUB_N    = 28;
   localparam int ST_REP_N    = 29;
endpackage
